// [hw/lvi_defs.svh]
// Constants for the level/vector interrupt structure
`ifndef LVI_DEFS_SVH
`define LVI_DEFS_SVH
`define LVI_NUM_LEVELS     8
`define LVI_NUM_VECTORS    26
`define LVI_MAX_VEC_PER_LV 128
`define LVI_VEC_BASE       8'hcc
`define LVI_MASK_RESET     8'h00
`define LVI_PRIO_RESET     8'h00
// Priority register field positions
`define LVI_PRIO_GRP0      0
`define LVI_PRIO_GRP1      1
`define LVI_PRIO_GRP2      2
`define LVI_PRIO_GRPA      3
`define LVI_PRIO_GRPB_SUB  4
`define LVI_PRIO_GRPC_SUB  5
`define LVI_PRIO_GRPC_NEST 6
`define LVI_PRIO_GRPB_NEST 7
`endif

// [hw/lvi_interrupt_ctrl.sv]
// Level/vector interrupt controller presenting requests to the CPU core
// Overview of operation
// - Eight levels, each one request line
// - Level number is identifier, not priority
// - Priority register drives group/subgroup arbitration
// - Up to 128 vectors per level
// - Level may own zero, one, many vectors
// - Fixed hardware order among level's vectors
// - One vector may serve several sources
// - Twenty-six vectors, one per source
// - Pending cleared by hardware or software
// - Level types one, two, three
// - Exactly two types used here
// - Pin events and overflows raise requests
// - Priority picks level, lowest vector wins
// - Grant disables interrupts, pushes, fetches address
// - Groups A 0-1, B 2-4, C 5-7
// - Per-level mask, read-only per-level pending
`timescale 1ns/1ps
`include "lvi_defs.svh"
module lvi_interrupt_ctrl
  import lvi_pkg::*;
#(
  parameter int NUM_VEC = `LVI_NUM_VECTORS
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  input  wire logic [NUM_VEC-1:0] src_event_in,
  input  wire logic [NUM_VEC-1:0] src_hw_clear_in,
  input  wire logic [NUM_VEC-1:0] src_sw_clear_in,
  input  wire logic [7:0]         level_priority_register_in,
  input  wire logic               level_priority_wr_in,
  input  wire logic [7:0]         level_mask_register_in,
  input  wire logic               level_mask_wr_in,
  input  wire logic               global_enable_in,
  input  wire logic               cpu_ack_in,
  input  wire logic               cpu_return_in,
  output logic                    cpu_req_out,
  output lvi_grant_t              grant_out,
  output logic                    int_disable_out,
  output logic                    push_ctx_out,
  output logic [7:0]              level_request_line_out,
  output logic [NUM_VEC-1:0]      src_pending_out,
  output logic [7:0]              level_mask_out,
  output logic [7:0]              level_priority_out
);
  // Fixed map from vector to level; two types used: single and multi-vector
  function automatic logic [2:0] vec_level(input int v);
    logic [2:0] r;
    r = 3'h0;
    if (v < 3) r = 3'h0;
    else if (v < 4) r = 3'h1;
    else if (v < 6) r = 3'h2;
    else if (v < 10) r = 3'h3;
    else if (v < 14) r = 3'h4;
    else if (v < 18) r = 3'h5;
    else if (v < 22) r = 3'h6;
    else r = 3'h7;
    return r;
  endfunction

  // Vector slots two bytes apart from the area base
  function automatic logic [7:0] vec_addr(input logic [4:0] v);
    return 8'(`LVI_VEC_BASE + {2'h0, v, 1'b0});
  endfunction

  logic [NUM_VEC-1:0] pend_r;
  logic [7:0]         mask_r;
  logic [7:0]         prio_r;
  lvi_state_t         state_r;
  lvi_grant_t         grant_r;
  logic               req_r;
  logic               dis_r;
  logic               push_r;
  logic [7:0]         lvl_r;
  logic [7:0]         lvl_nxt;
  logic [7:0]         active;
  logic               arb_any;
  logic [2:0]         arb_level;
  logic [4:0]         win_vec;
  logic               win_ok;

  // Per-source pending; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NUM_VEC; i++) begin
        if (src_event_in[i]) begin
          pend_r[i] <= 1'b1;
        end else if (src_sw_clear_in[i] ||
                     (src_hw_clear_in[i] && state_r == LVI_ACK && grant_r.vector_index == 5'(i))) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Mask and priority settings written by the core
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mask_r <= `LVI_MASK_RESET;
      prio_r <= `LVI_PRIO_RESET;
    end else begin
      if (level_mask_wr_in) mask_r <= level_mask_register_in;
      if (level_priority_wr_in) prio_r <= level_priority_register_in;
    end
  end

  // Level request lines: OR of each level's pending vectors
  always_comb begin
    lvl_nxt = '0;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (pend_r[i]) lvl_nxt[vec_level(i)] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) lvl_r <= '0;
    else lvl_r <= lvl_nxt;
  end

  assign active = lvl_nxt & mask_r;

  lvi_level_arbiter u_arb (
    .prio_in   (prio_r),
    .active_in (active),
    .any_out   (arb_any),
    .level_out (arb_level)
  );

  // Lowest-numbered pending vector of the chosen level wins; fixed order
  always_comb begin
    win_vec = 5'h0;
    win_ok  = 1'b0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (pend_r[i] && vec_level(i) == arb_level) begin
        win_vec = 5'(i);
        win_ok  = 1'b1;
      end
    end
  end

  // Request/grant sequence with the core
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= LVI_IDLE;
      grant_r <= '0;
      req_r   <= 1'b0;
      dis_r   <= 1'b0;
      push_r  <= 1'b0;
    end else begin
      push_r <= 1'b0;
      case (state_r)
        LVI_IDLE: begin
          if (global_enable_in && !dis_r && arb_any && win_ok) begin
            req_r                <= 1'b1;
            grant_r.valid        <= 1'b1;
            grant_r.level        <= arb_level;
            grant_r.vector_index <= win_vec;
            grant_r.vector_addr  <= vec_addr(win_vec);
            state_r              <= LVI_REQ;
          end
          if (cpu_return_in) dis_r <= 1'b0;
        end
        LVI_REQ: begin
          // Retract if the core disabled or the source went away
          if (!global_enable_in || !pend_r[grant_r.vector_index]) begin
            req_r         <= 1'b0;
            grant_r.valid <= 1'b0;
            state_r       <= LVI_IDLE;
          end else if (cpu_ack_in) begin
            req_r   <= 1'b0;
            dis_r   <= 1'b1;
            push_r  <= 1'b1;
            state_r <= LVI_ACK;
          end
        end
        LVI_ACK: begin
          grant_r.valid <= 1'b0;
          state_r       <= LVI_IDLE;
        end
        default: state_r <= LVI_IDLE;
      endcase
    end
  end

  always_comb begin
    cpu_req_out            = req_r;
    grant_out              = grant_r;
    int_disable_out        = dis_r;
    push_ctx_out           = push_r;
    level_request_line_out = lvl_r;
    src_pending_out        = pend_r;
    level_mask_out         = mask_r;
    level_priority_out     = prio_r;
  end

  // Request only when global enable was present the cycle before
  chk_req_needs_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(req_r) |-> $past(global_enable_in))
    else $error("request without enable");
  // Grant disables, pushes and withdraws the request in one step
  chk_ack_disables: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_REQ && cpu_ack_in && global_enable_in && pend_r[grant_r.vector_index]) |=> dis_r && push_r && !req_r)
    else $error("grant did not disable");
  // Source 0 event always lands in its pending flag
  chk_event_sets_pend: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    src_event_in[0] |=> pend_r[0])
    else $error("event lost");
  // Mask as it stood when the winner was chosen, indexed by the new level
  chk_mask_blocks_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(req_r) |-> |($past(mask_r) & (8'h01 << grant_r.level)))
    else $error("masked level requested");
  // Level 0 line follows its three vectors one cycle later
  chk_level_line: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 (lvl_r[0] == $past(|pend_r[2:0])))
    else $error("level 0 line wrong");
  // Address worked out apart from the function that builds it
  chk_vec_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    grant_r.valid |-> grant_r.vector_addr == 8'(`LVI_VEC_BASE + 2 * int'(grant_r.vector_index)))
    else $error("bad vector");
  // Core disabling before the grant withdraws the request
  chk_req_drops: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req_r && !global_enable_in) |=> !req_r)
    else $error("request held after disable");
  // Priority write lands on the next edge
  chk_prio_update: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    level_priority_wr_in |=> prio_r == $past(level_priority_register_in))
    else $error("priority lost");
  // Mask write lands on the next edge
  chk_mask_update: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    level_mask_wr_in |=> mask_r == $past(level_mask_register_in))
    else $error("mask lost");
  // A standing request always carries a valid grant
  chk_req_has_grant: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_r |-> grant_r.valid)
    else $error("request without grant");
  // Idle state never shows a request
  chk_idle_no_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_IDLE) |-> !req_r)
    else $error("request while idle");
  // No new request while a routine still runs
  chk_no_req_disabled: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(req_r) |-> $past(!dis_r))
    else $error("request while disabled");
  // Context push is a single-cycle pulse
  chk_push_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    push_r |=> !push_r)
    else $error("push held");
  // Push only follows an accepted grant
  chk_push_after_ack: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(push_r) |-> $past(state_r == LVI_REQ && cpu_ack_in))
    else $error("push without grant");
  // Acknowledge phase lasts one cycle and ends the grant
  chk_ack_ends_grant: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_ACK) |=> !grant_r.valid && state_r == LVI_IDLE)
    else $error("grant outlived acknowledge");
  // Disable holds until the routine returns
  chk_dis_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (dis_r && !cpu_return_in) |=> dis_r)
    else $error("disable dropped early");
  // Return from the routine re-enables
  chk_return_enables: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_IDLE && cpu_return_in) |=> !dis_r)
    else $error("return did not re-enable");
  // Hardware-cleared source loses its flag when granted
  chk_hw_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_ACK && src_hw_clear_in[grant_r.vector_index] && !src_event_in[grant_r.vector_index]) |=> !pend_r[grant_r.vector_index])
    else $error("hardware clear missed");
  // Software clear without a new event empties the flag
  chk_sw_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (src_sw_clear_in[4] && !src_event_in[4]) |=> !pend_r[4])
    else $error("software clear missed");
  // Source gone before the grant withdraws the request
  chk_retract_pend: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_r == LVI_REQ && !pend_r[grant_r.vector_index]) |=> !req_r)
    else $error("request held without source");
  // Grant must not shift under the core while it decides
  chk_grant_stable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (req_r && !cpu_ack_in && global_enable_in && pend_r[grant_r.vector_index]) |=> req_r && $stable(grant_r))
    else $error("grant moved while pending");
  // Granted vector belongs to the granted level
  chk_grant_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    grant_r.valid |-> grant_r.level == vec_level(grant_r.vector_index))
    else $error("vector outside level");
  // Level 1 line follows its single vector
  chk_level_one: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 (lvl_r[1] == $past(pend_r[3])))
    else $error("level 1 line wrong");
  // Level 7 line follows its four vectors
  chk_level_seven: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ##1 (lvl_r[7] == $past(|pend_r[25:22])))
    else $error("level 7 line wrong");
  // Request only when some enabled level had a winner
  chk_req_needs_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(req_r) |-> $past(arb_any && win_ok))
    else $error("request without active level");
  // Level 0: a later vector wins only if vector 0 was idle
  chk_lowest_in_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($rose(req_r) && grant_r.level == 3'h0 && grant_r.vector_index != 5'h0) |-> !$past(pend_r[0]))
    else $error("level 0 order broken");
  // Level 7: last vector wins only if the others were idle
  chk_last_in_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($rose(req_r) && grant_r.vector_index == 5'h19) |-> !$past(|pend_r[24:22]))
    else $error("level 7 order broken");
  // Granted index stays inside the implemented vectors
  chk_vec_in_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    grant_r.valid |-> grant_r.vector_index < 5'(NUM_VEC))
    else $error("vector index out of range");
endmodule

// [hw/lvi_level_arbiter.sv]
// Level arbiter: group and subgroup priority among eight levels
`timescale 1ns/1ps
`include "lvi_defs.svh"
module lvi_level_arbiter
  import lvi_pkg::*;
(
  input  wire logic [7:0] prio_in,
  input  wire logic [7:0] active_in,
  output logic            any_out,
  output logic [2:0]      level_out
);
  // Pick lower or upper member of a pair
  function automatic logic [2:0] pick2(input logic [1:0] act, input logic [2:0] base, input logic swap);
    logic [2:0] r;
    r = base;
    if (swap) begin
      r = act[1] ? base + 3'h1 : base;
    end else begin
      r = act[0] ? base : base + 3'h1;
    end
    return r;
  endfunction

  logic [2:0] lv_a;
  logic [2:0] lv_b;
  logic [2:0] lv_c;
  logic       act_a;
  logic       act_b;
  logic       act_c;

  // Group winners; subgroup bits set the inner order
  always_comb begin
    act_a = |active_in[1:0];
    act_b = |active_in[4:2];
    act_c = |active_in[7:5];
    lv_a  = pick2(active_in[1:0], 3'h0, prio_in[`LVI_PRIO_GRPA]);
    // Group B: level 2 alone vs subgroup {3,4}, nesting bit chooses which first
    if (active_in[2] && !(prio_in[`LVI_PRIO_GRPB_NEST] && |active_in[4:3])) begin
      lv_b = 3'h2;
    end else begin
      lv_b = pick2(active_in[4:3], 3'h3, prio_in[`LVI_PRIO_GRPB_SUB]);
    end
    // Group C: level 5 alone vs subgroup {6,7}
    if (active_in[5] && !(prio_in[`LVI_PRIO_GRPC_NEST] && |active_in[7:6])) begin
      lv_c = 3'h5;
    end else begin
      lv_c = pick2(active_in[7:6], 3'h6, prio_in[`LVI_PRIO_GRPC_SUB]);
    end
  end

  // Group order from three low bits, eight codes, two unused fall back
  always_comb begin
    any_out   = act_a | act_b | act_c;
    level_out = lv_a;
    case (prio_in[2:0])
      3'h1:    level_out = act_c ? lv_c : (act_a ? lv_a : lv_b);       // C>A>B
      3'h2:    level_out = act_a ? lv_a : (act_b ? lv_b : lv_c);       // A>B>C
      3'h3:    level_out = act_b ? lv_b : (act_a ? lv_a : lv_c);       // B>A>C
      3'h4:    level_out = act_c ? lv_c : (act_b ? lv_b : lv_a);       // C>B>A
      3'h5:    level_out = act_a ? lv_a : (act_c ? lv_c : lv_b);       // A>C>B
      3'h6:    level_out = act_b ? lv_b : (act_c ? lv_c : lv_a);       // B>C>A
      default: level_out = act_a ? lv_a : (act_b ? lv_b : lv_c);
    endcase
  end
endmodule

// [hw/lvi_pkg.sv]
// Types of the level/vector interrupt structure
package lvi_pkg;
  typedef logic [7:0] lvi_levels_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [4:0] vector_index;
    logic [7:0] vector_addr;
  } lvi_grant_t;
  typedef enum logic [1:0] {LVI_IDLE, LVI_REQ, LVI_ACK} lvi_state_t;
endpackage

// [tb/lvi_cpu_model.sv]
// Behavioural CPU core that grants and services requests
`timescale 1ns/1ps
module lvi_cpu_model
  import lvi_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        cpu_req_in,
  input  wire lvi_grant_t  grant_in,
  input  wire logic [25:0] hw_clear_in,
  input  wire logic [3:0]  ack_dly_in,
  output logic             ack_out,
  output logic             ret_out,
  output logic [25:0]      sw_clear_out
);
  logic [4:0] vec_r;
  initial begin
    ack_out = 1'b0;
    ret_out = 1'b0;
    sw_clear_out = '0;
  end
  // Grant after a chosen delay; a retracted request is left alone
  always begin
    @(posedge clk_sys_in);
    #1;
    if (!rst_in && cpu_req_in) begin
      repeat (ack_dly_in) begin
        @(posedge clk_sys_in);
        #1;
      end
      if (cpu_req_in) begin
        ack_out = 1'b1;
        vec_r = grant_in.vector_index;
        @(posedge clk_sys_in);
        #1 ack_out = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        // Routine clears only sources the hardware does not clear
        #1 sw_clear_out[vec_r] = !hw_clear_in[vec_r];
        @(posedge clk_sys_in);
        #1 sw_clear_out = '0;
        ret_out = 1'b1;
        @(posedge clk_sys_in);
        #1 ret_out = 1'b0;
      end
    end
  end
endmodule

// [tb/lvi_interrupt_ctrl_tb.sv]
// Self-checking bench for the level/vector interrupt controller
`timescale 1ns/1ps
module lvi_interrupt_ctrl_tb
  import lvi_pkg::*;
;
  typedef struct packed {
    logic [25:0] evt;
    logic [7:0]  mask;
    logic [7:0]  prio;
    logic [4:0]  idx;
  } lvi_row_t;
  localparam logic [25:0] ALL = 26'h204886e;
  logic        clk_sys_in, rst_in, ge, ack, ret, prio_wr, mask_wr, req, dis, push;
  logic [25:0] evt, hwc, swc, pend;
  logic [7:0]  prio, mask, lines, mask_o, prio_o;
  logic [3:0]  dly;
  lvi_grant_t  grant;
  int          miscompares, compares;
  // Winner per priority setting; all levels raised unless masked
  lvi_row_t rows [13] = '{'{ALL, 8'hff, 8'h00, 5'h01}, '{ALL, 8'hff, 8'h01, 5'h0f},
    '{ALL, 8'hff, 8'h03, 5'h05}, '{ALL, 8'hff, 8'h08, 5'h03}, '{ALL, 8'h1f, 8'h84, 5'h06},
    '{ALL, 8'h1f, 8'h94, 5'h0b}, '{ALL, 8'hff, 8'h44, 5'h12}, '{ALL, 8'hff, 8'h64, 5'h19},
    '{ALL, 8'hfe, 8'h00, 5'h03}, '{ALL, 8'he3, 8'h06, 5'h0f}, '{ALL, 8'hfc, 8'h05, 5'h0f},
    '{ALL, 8'hfc, 8'h02, 5'h05}, '{ALL, 8'hff, 8'h07, 5'h01}};
  lvi_interrupt_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .src_event_in(evt),
    .src_hw_clear_in(hwc), .src_sw_clear_in(swc), .level_priority_register_in(prio),
    .level_priority_wr_in(prio_wr), .level_mask_register_in(mask), .level_mask_wr_in(mask_wr),
    .global_enable_in(ge), .cpu_ack_in(ack), .cpu_return_in(ret), .cpu_req_out(req),
    .grant_out(grant), .int_disable_out(dis), .push_ctx_out(push), .level_request_line_out(lines),
    .src_pending_out(pend), .level_mask_out(mask_o), .level_priority_out(prio_o));
  lvi_cpu_model core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cpu_req_in(req), .grant_in(grant),
    .hw_clear_in(hwc), .ack_dly_in(dly), .ack_out(ack), .ret_out(ret), .sw_clear_out(swc));
  // Free-running system clock
  always #12.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [2:0] lvl_of(input logic [4:0] i);
    if (i < 5'd3)
      return 3'h0;
    if (i < 5'd6)
      return (i == 5'd3) ? 3'h1 : 3'h2;
    return 3'(3 + (i - 6) / 4);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Inputs change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Long tail lets the core model finish any service in flight
  task automatic do_reset();
    rst_in = 1'b1;
    tick(4);
    rst_in = 1'b0;
    tick(8);
  endtask
  task automatic cfg(input logic [7:0] p, input logic [7:0] m);
    prio = p;
    mask = m;
    prio_wr = 1'b1;
    mask_wr = 1'b1;
    tick(1);
    prio_wr = 1'b0;
    mask_wr = 1'b0;
  endtask
  task automatic pulse(input logic [25:0] e);
    evt = e;
    tick(1);
    evt = '0;
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while (req !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    if (req !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Main sequence: table first, then hand-written cases
  initial begin
    {clk_sys_in, ge, prio_wr, mask_wr, prio, mask, evt, hwc, dly} = '0;
    miscompares = 0;
    compares = 0;
    do_reset();
    chk(pend, 26'h0);
    chk({req, dis, push, lines, mask_o, prio_o}, 27'h0);
    ge = 1'b1;
    foreach (rows[k]) begin
      do_reset();
      cfg(rows[k].prio, rows[k].mask);
      pulse(rows[k].evt);
      wait_req();
      chk(grant.level, lvl_of(rows[k].idx));
      chk(grant.vector_index, rows[k].idx);
      chk({grant.valid, mask_o, prio_o}, {1'b1, rows[k].mask, rows[k].prio});
    end
    // Every source on its own vector, core answering promptly and slowly
    for (int i = 0; i < 26; i++) begin
      dly = 4'(i % 4);
      do_reset();
      cfg(8'h00, 8'hff);
      pulse(26'h1 << i);
      wait_req();
      chk(grant.vector_index, i[4:0]);
      chk(grant.vector_addr, 8'hcc + 8'(2 * i));
      chk(lines, 8'h1 << lvl_of(i[4:0]));
    end
    // Grant blocks others; hardware and software clears
    dly = 4'h0;
    hwc = 26'h1;
    do_reset();
    cfg(8'h00, 8'hff);
    pulse(26'h11);
    wait_req();
    chk(grant.vector_index, 32'h0);
    tick(1);
    chk({req, dis, push}, 3'b011);
    tick(2);
    chk({req, pend[0], pend[4]}, 3'b001);
    wait_req();
    chk(grant.vector_index, 32'h4);
    tick(10);
    chk(pend, 26'h0);
    // Nothing reaches the core while disabled or masked
    hwc = 26'h0;
    ge = 1'b0;
    pulse(26'h40);
    tick(5);
    chk({req, lines}, 9'h008);
    ge = 1'b1;
    wait_req();
    chk(grant.vector_index, 32'h6);
    do_reset();
    cfg(8'h00, 8'h00);
    pulse(26'h40);
    tick(5);
    chk({req, mask_o}, 9'h000);
    // Slow core: request withdrawn when enable drops before the grant
    dly = 4'hf;
    cfg(8'h00, 8'hff);
    wait_req();
    ge = 1'b0;
    tick(1);
    chk({req, grant.valid, pend[6]}, 3'b001);
    tally_and_finish();
  end
endmodule
